// *** core/dtc_ahb_slave.v ***
// Purpose: AHB-Lite slave front end
// Assumes: single word transfers, zero wait states
// Notes: response always OKAY; unmapped reads give zero
`timescale 1ns/1ns
`include "dtc_map.vh"
module dtc_ahb_slave (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // AHB-Lite
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    // Register side
    output wire wr_o,
    output wire [7:0] addr_o,
    output wire [15:0] wdata_o,
    input wire [15:0] rdata_i
);
    reg wr_q;
    reg [7:0] addr_q;
    wire take;
    assign take = hsel_i & htrans_i[1] & hready_i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_q <= take & hwrite_i;
            if (take) begin
                addr_q <= haddr_i;
            end
        end
    end
    // Read data combinational in the data phase
    assign hrdata_o = {16'h0000, rdata_i};
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign wr_o = wr_q;
    assign addr_o = addr_q;
    assign wdata_o = hwdata_i[15:0];
endmodule

// *** core/dtc_ctrl.v ***
// Purpose: trigger, calibration and analog output control registers
// Assumes: 20 MHz clk_i, synchronous active-high reset, AHB-Lite register access
// Notes: comparator results and the external trigger are asynchronous pins
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
`include "dtc_map.vh"
// Overview of operation
// R1: writing 1 to trigger bit 7 clears the trigger latch; latch reads bit 7.
// R2: no threshold enables: polarity bit picks negative or positive hysteresis.
// R3: single enable: low-only triggers below low, high-only triggers above high.
// R4: both enables: trigger high inside the threshold window, low outside.
// R5: software programs high threshold via output 1, low via output 0, high>=low.
// R6: a full acquisition FIFO is 512 samples, half is 256.
// R7: normal mode arming; mode bit 1 small counts start counter on pacer.
// R8: counts above one FIFO: arm when remaining under one FIFO, start on half-full.
// R9: pre-trigger small counts: arm after index done; mode 1 starts by software.
// R10: timebase bit 1 picks internal 10MHz, 0 picks external counter clock pin.
// R11: trigger bit 12 reads 1 once pre-trigger index counter has completed.
// R12: calibration bits 7:0 are the offset code, mid-scale 7Fh by default.
// R13: trim DAC and potentiometer selects; bit 15 is their serial data.
// R14: offset DAC converts the code when update is 1, holds when 0.
// R15: three-bit calibration source picks ground, references, or output voltages.
// R16: calibration enable routes selected source into analog input channel 0.
// R17: writing 1 to output bit 0 clears the latched output-FIFO-empty flag.
// R18: output enable bit enables both analog output channels.
// R19: start bit runs FIFO output, or arms for external trigger; 0 disables.
// R20: output pacer field bits 4:3: software, internal, falling, rising.
// R21: fast mode field bits 6:5: off, channel 0, channel 1, both.
// R22: per-channel range field: bipolar 5V, bipolar 10V, unipolar 5V, unipolar 10V.
// R23: comparator results are synchronised before the trigger mode decode.
module dtc_ctrl (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // AHB-Lite slave
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    // Analog trigger comparators and external trigger
    input wire above_high_i,
    input wire below_low_i,
    input wire ext_trigger_i,
    output wire analog_trigger_o,
    // Acquisition arming and sample counter
    input wire index_count_done_i,
    input wire adc_fifo_half_full_i,
    input wire adc_pacer_i,
    input wire sw_counter_start_i,
    output wire pretrigger_enable_o,
    output wire acq_armed_o,
    output wire sample_counter_start_o,
    // User counter 0 timebase
    input wire osc_10mhz_i,
    input wire counter0_external_timebase_i,
    output wire counter0_clock_o,
    // Calibration
    output wire [7:0] offset_cal_code_o,
    output wire offset_dac_update_o,
    output wire [7:0] offset_dac_value_o,
    output wire trim_dac_select_o,
    output wire trim_pot_select_o,
    output wire trim_serial_in_o,
    output wire [2:0] cal_source_select_o,
    output wire [7:0] cal_source_onehot_o,
    output wire cal_route_enable_o,
    // Analog output control
    input wire out_fifo_empty_i,
    input wire output_external_trigger_i,
    input wire output_external_trigger_used_i,
    output wire analog_out_enable_o,
    output wire output_running_o,
    output wire output_armed_o,
    output wire [1:0] output_pacer_source_o,
    output wire [1:0] output_fast_mode_o,
    output wire [1:0] ch0_output_range_select_o,
    output wire [1:0] ch1_output_range_select_o
);
    // ==========================================================
    // Bus front end
    wire wr;
    wire [7:0] addr;
    wire [15:0] wdata;
    reg [15:0] rdata;
    dtc_ahb_slave u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hready_i(hready_i),
        .hwdata_i(hwdata_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .wr_o(wr),
        .addr_o(addr),
        .wdata_o(wdata),
        .rdata_i(rdata)
    );
    wire wr_trig = wr & (addr == `DTC_ADDR_TRIG);
    wire wr_cal = wr & (addr == `DTC_ADDR_CAL);
    wire wr_aout = wr & (addr == `DTC_ADDR_AOUT);

    // ==========================================================
    // Asynchronous inputs
    wire [3:0] sync_q;
    dtc_sync3 #(
        .W(4)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({output_external_trigger_i, ext_trigger_i, below_low_i, above_high_i}),
        .q_o(sync_q)
    );
    wire above_high = sync_q[0]; // see R23
    wire below_low = sync_q[1]; // see R23
    wire ext_trig = sync_q[2];
    wire out_ext_trig = sync_q[3];

    // ==========================================================
    // Trigger register
    reg low_en_q;
    reg high_en_q;
    reg hpol_q;
    reg arm_q;
    reg ffm_q;
    reg tbsel_q;
    reg pre_q;
    reg latched_q;
    reg ext_trig_d1_q;
    reg analog_trigger_input_q;
    reg analog_trigger_input_d;
    always @(posedge clk_i) begin
        if (rst_i) begin
            low_en_q <= 1'b0;
            high_en_q <= 1'b0;
            hpol_q <= 1'b0;
            arm_q <= 1'b0;
            ffm_q <= 1'b0;
            tbsel_q <= 1'b0;
            pre_q <= 1'b0;
        end else if (wr_trig) begin
            low_en_q <= wdata[`DTC_TRG_LOW_THRESHOLD_ENABLE];
            high_en_q <= wdata[`DTC_TRG_HIGH_THRESHOLD_ENABLE];
            hpol_q <= wdata[`DTC_TRG_HPOL];
            arm_q <= wdata[`DTC_TRG_ARM];
            ffm_q <= wdata[`DTC_TRG_FFM];
            tbsel_q <= wdata[`DTC_TRG_TBSEL];
            pre_q <= wdata[`DTC_TRG_PRE];
        end
    end
    // Trigger edge sets, a same-cycle clear loses to it
    wire ext_rise = ext_trig & ~ext_trig_d1_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_trig_d1_q <= 1'b0;
            latched_q <= 1'b0;
        end else begin
            ext_trig_d1_q <= ext_trig;
            if (ext_rise) begin
                latched_q <= 1'b1;
            end else if (wr_trig & wdata[`DTC_TRG_XCLR]) begin
                latched_q <= 1'b0; // see R1
            end
        end
    end

    // ==========================================================
    // Analog trigger mode decode
    always @* begin
        analog_trigger_input_d = analog_trigger_input_q;
        case ({high_en_q, low_en_q})
            2'b00: begin
                if (!hpol_q) begin
                    if (above_high) begin
                        analog_trigger_input_d = 1'b1; // see R2
                    end else if (below_low) begin
                        analog_trigger_input_d = 1'b0; // see R2
                    end
                end else begin
                    if (below_low) begin
                        analog_trigger_input_d = 1'b1; // see R2
                    end else if (above_high) begin
                        analog_trigger_input_d = 1'b0; // see R2
                    end
                end
            end
            2'b01: analog_trigger_input_d = below_low; // see R3
            2'b10: analog_trigger_input_d = above_high; // see R3
            2'b11: analog_trigger_input_d = ~above_high & ~below_low; // see R4
            default: analog_trigger_input_d = 1'b0;
        endcase
    end
    // Thresholds come from the output channels
    always @(posedge clk_i) begin
        if (rst_i) begin
            analog_trigger_input_q <= 1'b0;
        end else begin
            analog_trigger_input_q <= analog_trigger_input_d;
        end
    end
    assign analog_trigger_o = analog_trigger_input_q;

    // ==========================================================
    // FIFO arming and sample counter start
    // Software picks the mode from counts against 512 and 256, see R6
    reg start_q;
    reg start_d;
    always @* begin
        start_d = 1'b0;
        if (arm_q) begin
            if (!ffm_q) begin
                start_d = adc_fifo_half_full_i; // see R7 see R8
            end else if (!pre_q) begin
                start_d = adc_pacer_i; // see R7
            end else begin
                start_d = sw_counter_start_i & index_count_done_i; // see R9
            end
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
        end
    end
    assign acq_armed_o = arm_q;
    assign pretrigger_enable_o = pre_q;
    assign sample_counter_start_o = start_q;

    // Combinational mux; glitch-free switching left to the counter
    assign counter0_clock_o = tbsel_q ? osc_10mhz_i : counter0_external_timebase_i; // see R10

    // ==========================================================
    // Calibration register
    reg [15:0] cal_q;
    reg [7:0] offset_dac_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cal_q <= {8'h00, `DTC_CAL_CODE_RST}; // see R12
            offset_dac_q <= `DTC_CAL_CODE_RST;
        end else begin
            if (wr_cal) begin
                cal_q <= wdata;
            end
            if (cal_q[`DTC_CAL_UPD]) begin
                offset_dac_q <= cal_q[7:0]; // see R14
            end
        end
    end
    assign offset_cal_code_o = cal_q[7:0]; // see R12
    assign offset_dac_update_o = cal_q[`DTC_CAL_UPD];
    assign offset_dac_value_o = offset_dac_q;
    assign trim_dac_select_o = cal_q[`DTC_CAL_TRIM]; // see R13
    assign trim_pot_select_o = cal_q[`DTC_CAL_POT]; // see R13
    assign trim_serial_in_o = cal_q[`DTC_CAL_SDI]; // see R13
    assign cal_source_select_o = cal_q[`DTC_CAL_SRC_LO+2:`DTC_CAL_SRC_LO];
    assign cal_route_enable_o = cal_q[`DTC_CAL_EN]; // see R16
    // One-hot source switches, all open unless routing on
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : cal_source_select
            localparam [2:0] SRC = g;
            assign cal_source_onehot_o[g] = cal_q[`DTC_CAL_EN] &
                (cal_q[`DTC_CAL_SRC_LO+2:`DTC_CAL_SRC_LO] == SRC); // see R15 see R16
        end
    endgenerate

    // ==========================================================
    // Analog output control
    reg en_q;
    reg start_bit_q;
    reg [1:0] pacer_q;
    reg [1:0] fast_q;
    reg [3:0] range_q;
    reg empty_q;
    reg run_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
            start_bit_q <= 1'b0;
            pacer_q <= 2'b00;
            fast_q <= 2'b00;
            range_q <= 4'h0;
        end else if (wr_aout) begin
            en_q <= wdata[`DTC_AO_EN]; // see R18
            start_bit_q <= wdata[`DTC_AO_START];
            pacer_q <= wdata[`DTC_AO_PACER_LO+1:`DTC_AO_PACER_LO]; // see R20
            fast_q <= wdata[`DTC_AO_FAST_LO+1:`DTC_AO_FAST_LO]; // see R21
            range_q <= wdata[`DTC_AO_RANGE_LO+3:`DTC_AO_RANGE_LO]; // see R22
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            empty_q <= 1'b0;
        end else if (out_fifo_empty_i & run_q) begin
            empty_q <= 1'b1;
        end else if (wr_aout & wdata[`DTC_AO_ECLR]) begin
            empty_q <= 1'b0; // see R17
        end
    end
    // Start runs at once or waits for the external trigger
    always @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
        end else if (!start_bit_q) begin
            run_q <= 1'b0; // see R19
        end else if (!output_external_trigger_used_i | out_ext_trig) begin
            run_q <= 1'b1; // see R19
        end
    end
    assign analog_out_enable_o = en_q;
    assign output_running_o = run_q;
    assign output_armed_o = start_bit_q & ~run_q;
    assign output_pacer_source_o = pacer_q;
    assign output_fast_mode_o = fast_q;
    assign ch0_output_range_select_o = range_q[1:0];
    assign ch1_output_range_select_o = range_q[3:2];

    // ==========================================================
    // Read back; calibration is write-only
    always @* begin
        rdata = 16'h0000;
        if (addr == `DTC_ADDR_TRIG) begin
            rdata[`DTC_TRG_LATCHED] = latched_q; // see R1
            rdata[`DTC_TRG_IDXDONE] = index_count_done_i; // see R11
        end else if (addr == `DTC_ADDR_AOUT) begin
            rdata[0] = empty_q;
        end
    end
endmodule

// *** core/dtc_map.vh ***
// Purpose: constants for the control block
// Assumes: 32-bit bus words, 16-bit registers in the low half
// Notes: byte address is four times the register index
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
// ==========================================================
// Register indexes and byte addresses
`define DTC_IDX_TRIG 4'h4
`define DTC_IDX_CAL 4'h6
`define DTC_IDX_AOUT 4'h8
`define DTC_ADDR_TRIG 8'h10
`define DTC_ADDR_CAL 8'h18
`define DTC_ADDR_AOUT 8'h20
// ==========================================================
// Trigger register fields
`define DTC_TRG_XCLR 7
`define DTC_TRG_LOW_THRESHOLD_ENABLE 8
`define DTC_TRG_HIGH_THRESHOLD_ENABLE 9
`define DTC_TRG_HPOL 10
`define DTC_TRG_ARM 11
`define DTC_TRG_FFM 12
`define DTC_TRG_TBSEL 13
`define DTC_TRG_PRE 6
`define DTC_TRG_LATCHED 7
`define DTC_TRG_IDXDONE 12
// ==========================================================
// Calibration register fields
`define DTC_CAL_TRIM 8
`define DTC_CAL_POT 9
`define DTC_CAL_UPD 10
`define DTC_CAL_SRC_LO 11
`define DTC_CAL_EN 14
`define DTC_CAL_SDI 15
`define DTC_CAL_CODE_RST 8'h7F
// ==========================================================
// Analog output control fields
`define DTC_AO_ECLR 0
`define DTC_AO_EN 1
`define DTC_AO_START 2
`define DTC_AO_PACER_LO 3
`define DTC_AO_FAST_LO 5
`define DTC_AO_RANGE_LO 8
// ==========================================================
// Acquisition FIFO sizes in samples
`define DTC_FIFO_FULL 16'h0200
`define DTC_FIFO_HALF 16'h0100
`endif

// *** core/dtc_sync3.v ***
// Purpose: three-stage synchroniser
// Assumes: asynchronous input
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module dtc_sync3 #(
    parameter W = 2
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Data
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    reg [W-1:0] out_q;
    genvar g;
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    generate
        for (g = 0; g < W; g = g + 1) begin : agree
            always @(posedge clk_i) begin
                if (rst_i) begin
                    out_q[g] <= 1'b0;
                end else if (s2_q[g] == s3_q[g]) begin
                    out_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate
    assign q_o = out_q;
endmodule

// *** testbench/daq_trigger_cal_dac_control_bench.sv ***
// Purpose: directed register tests of the control block
// Assumes: pin inputs settle within eight cycles
// Notes: hsel and hsize fixed, hready from hreadyout
`timescale 1ns/1ns
`include "dtc_map.vh"
module daq_trigger_cal_dac_control_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b1, hwrite_i = 1'b0;
    logic [7:0] haddr_i = 8'h0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0, hrdata_o, rd_q, rd_v;
    logic hreadyout_o, hresp_o, hready_i, analog_trigger_o, pretrigger_enable_o, acq_armed_o;
    logic above_high_i = 1'b0, below_low_i = 1'b0, ext_trigger_i = 1'b0, index_count_done_i = 1'b0;
    logic adc_fifo_half_full_i = 1'b0, adc_pacer_i = 1'b0, sw_counter_start_i = 1'b0;
    logic osc_10mhz_i = 1'b0, counter0_external_timebase_i = 1'b0, out_fifo_empty_i = 1'b0;
    logic output_external_trigger_i = 1'b0, output_external_trigger_used_i = 1'b0;
    logic sample_counter_start_o, counter0_clock_o, offset_dac_update_o, trim_dac_select_o;
    logic trim_pot_select_o, trim_serial_in_o, cal_route_enable_o, analog_out_enable_o;
    logic output_running_o, output_armed_o;
    logic [7:0] offset_cal_code_o, offset_dac_value_o, cal_source_onehot_o;
    logic [2:0] cal_source_select_o;
    logic [1:0] output_pacer_source_o, output_fast_mode_o, ch0_output_range_select_o, ch1_output_range_select_o;
    int errors = 0, n_tests = 0;
    // Rows: hi en, lo en, pol, above, below, expected
    logic [5:0] tt [16] = '{6'h05, 6'h01, 6'h02, 6'h00, 6'h0B, 6'h09, 6'h0C, 6'h13,
                            6'h14, 6'h10, 6'h25, 6'h22, 6'h31, 6'h34, 6'h3A, 6'h39};
    logic [31:0] sc_w [3] = '{32'h0800, 32'h1800, 32'h1840};
    assign hready_i = hreadyout_o;
    dtc_ctrl dtc_ctrl_inst (.*);
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) rd_q <= hrdata_o;
    // ==========================================================
    // Tasks
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Read data captured at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        #1 rd_v = rd_q;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd_v);
    endtask
    // ==========================================================
    // Tests
    initial begin
        tick(20);
        rst_i <= 1'b0;
        tick(1);
        chk("reset code", 32'h7F, {24'h0, offset_cal_code_o});
        chk("reset dac", 32'h7F, {24'h0, offset_dac_value_o});
        rd("reset trig", `DTC_ADDR_TRIG, 32'h0);
        rd("reset aout", `DTC_ADDR_AOUT, 32'h0);
        rd("unmapped", 8'h3C, 32'h0);
        for (int i = 0; i < 16; i++) begin
            wr(`DTC_ADDR_TRIG, {21'h0, tt[i][3], tt[i][5], tt[i][4], 8'h0});
            above_high_i <= tt[i][2];
            below_low_i <= tt[i][1];
            tick(10);
            chk("analog trigger", {31'h0, tt[i][0]}, {31'h0, analog_trigger_o});
        end
        ext_trigger_i <= 1'b1;
        tick(6);
        ext_trigger_i <= 1'b0;
        tick(4);
        rd("latch set", `DTC_ADDR_TRIG, 32'h80);
        wr(`DTC_ADDR_TRIG, 32'h0);
        rd("latch kept", `DTC_ADDR_TRIG, 32'h80);
        wr(`DTC_ADDR_TRIG, 32'h80);
        rd("latch clear", `DTC_ADDR_TRIG, 32'h0);
        index_count_done_i <= 1'b1;
        tick(1);
        rd("index done", `DTC_ADDR_TRIG, 32'h1000);
        for (int k = 0; k < 4; k++) begin
            wr(`DTC_ADDR_TRIG, k < 2 ? 32'h2000 : 32'h0);
            osc_10mhz_i <= k[0];
            counter0_external_timebase_i <= ~k[0];
            tick(1);
            chk("timebase", {31'h0, k < 2 ? k[0] : ~k[0]}, {31'h0, counter0_clock_o});
        end
        for (int c = 0; c < 3; c++) begin
            index_count_done_i <= (c == 2);
            wr(`DTC_ADDR_TRIG, sc_w[c]);
            chk("armed", 32'h1, {31'h0, acq_armed_o});
            chk("pretrigger", {31'h0, c == 2}, {31'h0, pretrigger_enable_o});
            {adc_fifo_half_full_i, adc_pacer_i, sw_counter_start_i} <= 3'h4 >> c;
            tick(1);
            {adc_fifo_half_full_i, adc_pacer_i, sw_counter_start_i} <= 3'h0;
            for (int w = 0; w < 4 && sample_counter_start_o !== 1'b1; w++) tick(1);
            chk("counter start", 32'h1, {31'h0, sample_counter_start_o});
        end
        index_count_done_i <= 1'b0;
        wr(`DTC_ADDR_TRIG, 32'h0);
        rd("index idle", `DTC_ADDR_TRIG, 32'h0);
        wr(`DTC_ADDR_CAL, 32'hE95A);
        chk("cal code", 32'h5A, {24'h0, offset_cal_code_o});
        chk("dac held", 32'h7F, {24'h0, offset_dac_value_o});
        chk("cal selects", 32'h5, {29'h0, trim_serial_in_o, trim_pot_select_o, trim_dac_select_o});
        chk("cal onehot", 32'h20, {24'h0, cal_source_onehot_o});
        rd("cal write only", `DTC_ADDR_CAL, 32'h0);
        for (int s = 0; s < 8; s++) begin
            wr(`DTC_ADDR_CAL, 32'h46A5 | (s << 11));
            tick(1);
            chk("cal source", 32'h1 << s, {24'h0, cal_source_onehot_o});
            chk("dac follow", 32'hA5, {24'h0, offset_dac_value_o});
        end
        wr(`DTC_ADDR_CAL, 32'h0011);
        tick(1);
        chk("cal off", 32'h0, {24'h0, cal_source_onehot_o});
        chk("dac hold", 32'hA5, {24'h0, offset_dac_value_o});
        for (int i = 0; i < 4; i++) begin
            wr(`DTC_ADDR_AOUT, 32'h2 | (i << 3) | (i << 5) | (i << 8) | ((3 - i) << 10));
            chk("pacer", i, {30'h0, output_pacer_source_o});
            chk("fast mode", i, {30'h0, output_fast_mode_o});
            chk("range 0", i, {30'h0, ch0_output_range_select_o});
            chk("range 1", 3 - i, {30'h0, ch1_output_range_select_o});
        end
        output_external_trigger_used_i <= 1'b1;
        wr(`DTC_ADDR_AOUT, 32'h6);
        chk("out armed", 32'h2, {30'h0, output_armed_o, output_running_o});
        output_external_trigger_i <= 1'b1;
        tick(6);
        output_external_trigger_i <= 1'b0;
        tick(2);
        chk("out running", 32'h2, {30'h0, output_running_o, output_armed_o});
        out_fifo_empty_i <= 1'b1;
        tick(2);
        out_fifo_empty_i <= 1'b0;
        rd("empty latched", `DTC_ADDR_AOUT, 32'h1);
        wr(`DTC_ADDR_AOUT, 32'h6);
        rd("empty kept", `DTC_ADDR_AOUT, 32'h1);
        wr(`DTC_ADDR_AOUT, 32'h7);
        rd("empty clear", `DTC_ADDR_AOUT, 32'h0);
        wr(`DTC_ADDR_AOUT, 32'h0);
        tick(1);
        chk("out stop", 32'h0, {30'h0, output_running_o, analog_out_enable_o});
        output_external_trigger_used_i <= 1'b0;
        wr(`DTC_ADDR_AOUT, 32'h6);
        tick(2);
        chk("out direct", 32'h1, {30'h0, output_armed_o, output_running_o});
        end_sim();
    end
    // Whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        end_sim();
    end
endmodule
bind dtc_ctrl dtc_ctrl_props dtc_ctrl_props_inst (.*);

// *** testbench/dtc_ctrl_props.sv ***
// Purpose: concurrent checks on the control block
// Assumes: zero-wait bus, writes land at data-phase end
// Notes: shadow bits mirror trigger writes
`timescale 1ns/1ns
`include "dtc_map.vh"
module dtc_ctrl_props (
    // Clock, reset and bus
    input logic clk_i,
    input logic rst_i,
    input logic hsel_i,
    input logic [7:0] haddr_i,
    input logic [1:0] htrans_i,
    input logic hwrite_i,
    input logic hready_i,
    input logic [31:0] hwdata_i,
    input logic hreadyout_o,
    input logic hresp_o,
    // Trigger and counter
    input logic above_high_i,
    input logic below_low_i,
    input logic analog_trigger_o,
    input logic pretrigger_enable_o,
    input logic acq_armed_o,
    input logic osc_10mhz_i,
    input logic counter0_external_timebase_i,
    input logic counter0_clock_o,
    // Calibration and output control
    input logic [7:0] offset_cal_code_o,
    input logic offset_dac_update_o,
    input logic [7:0] offset_dac_value_o,
    input logic [2:0] cal_source_select_o,
    input logic [7:0] cal_source_onehot_o,
    input logic cal_route_enable_o,
    input logic analog_out_enable_o,
    input logic [1:0] output_pacer_source_o,
    input logic [1:0] output_fast_mode_o,
    input logic [1:0] ch0_output_range_select_o,
    input logic [1:0] ch1_output_range_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Bus write shadow
    logic wp_q, lo_q, hi_q, tb_q;
    logic [7:0] wa_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            {wp_q, lo_q, hi_q, tb_q} <= 4'h0;
            wa_q <= 8'h0;
        end else begin
            wp_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
            wa_q <= haddr_i;
            if (wp_q && wa_q == `DTC_ADDR_TRIG) begin
                lo_q <= hwdata_i[8];
                hi_q <= hwdata_i[9];
                tb_q <= hwdata_i[13];
            end
        end
    end
    // ==========================================================
    // Properties
    property p_cal_wr;
        wp_q && wa_q == `DTC_ADDR_CAL |=> offset_cal_code_o == $past(hwdata_i[7:0])
            && cal_source_select_o == $past(hwdata_i[13:11]) && cal_route_enable_o == $past(hwdata_i[14]);
    endproperty
    a_cal_wr: assert property (p_cal_wr) else $error("calibration fields differ");
    property p_ao_wr;
        wp_q && wa_q == `DTC_ADDR_AOUT |=> analog_out_enable_o == $past(hwdata_i[1])
            && {ch1_output_range_select_o, ch0_output_range_select_o} == $past(hwdata_i[11:8])
            && {output_fast_mode_o, output_pacer_source_o} == $past(hwdata_i[6:3]);
    endproperty
    a_ao_wr: assert property (p_ao_wr) else $error("output control fields differ");
    property p_trg_wr;
        wp_q && wa_q == `DTC_ADDR_TRIG |=> pretrigger_enable_o == $past(hwdata_i[6])
            && acq_armed_o == $past(hwdata_i[11]);
    endproperty
    a_trg_wr: assert property (p_trg_wr) else $error("trigger mode bits differ");
    property p_onehot;
        cal_source_onehot_o == (cal_route_enable_o ? (8'h1 << cal_source_select_o) : 8'h0);
    endproperty
    a_onehot: assert property (p_onehot) else $error("calibration source routing wrong");
    property p_dac_hold;
        !offset_dac_update_o |=> $stable(offset_dac_value_o);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("offset value moved while held");
    property p_dac_follow;
        offset_dac_update_o |=> offset_dac_value_o == $past(offset_cal_code_o);
    endproperty
    a_dac_follow: assert property (p_dac_follow) else $error("offset value not converted");
    property p_bus_okay;
        hreadyout_o && !hresp_o;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
    property p_window;
        (lo_q && hi_q && !above_high_i && !below_low_i)[*7] |-> analog_trigger_o;
    endproperty
    a_window: assert property (p_window) else $error("window mode not high inside");
    property p_cnt_clk;
        counter0_clock_o == (tb_q ? osc_10mhz_i : counter0_external_timebase_i);
    endproperty
    a_cnt_clk: assert property (p_cnt_clk) else $error("counter timebase wrong");
endmodule
